// ---- inc/spi_ctrl_pkg.sv ----
// Constants and types for the SPI interrupt, DMA and FIFO control slice.
// Assumes a 32-bit APB register bus and a single system clock.
package spi_ctrl_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_IMSC = 12'h014;
	localparam logic [11:0] OFS_RIS = 12'h018;
	localparam logic [11:0] OFS_MASKED_STATUS = 12'h01C;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h020;
	localparam logic [11:0] OFS_DMA_CTRL = 12'h024;
	localparam logic [11:0] OFS_RX_FRAMES = 12'h028;
	localparam logic [11:0] OFS_DUMMY = 12'h02C;
	localparam logic [11:0] OFS_TX_FRAMES = 12'h030;
	localparam logic [11:0] OFS_TEST_CTRL = 12'h080;
	localparam logic [11:0] OFS_TEST_PORT = 12'h08C;

	// ==========================================================
	// Field positions
	localparam int IRQ_ROR = 0;
	localparam int IRQ_RT = 1;
	localparam int IRQ_RX = 2;
	localparam int IRQ_TX = 3;
	localparam int IRQ_TUR = 4;
	localparam int IRQ_TE = 5;
	localparam int IRQ_W = 6;
	localparam int CLR_ROR = 0;
	localparam int CLR_RT = 1;
	localparam int CLR_TUR = 2;
	localparam int DMA_RX_BIT = 0;
	localparam int DMA_TX_BIT = 2;
	localparam int SWAP_BIT = 1;
	localparam int CNT_W = 16;

	// ==========================================================
	// Reset values
	localparam logic [5:0] IMSC_RESET = 6'h00;
	localparam logic [15:0] RX_FRAMES_RESET = 16'h0000;
	localparam logic [15:0] TX_FRAMES_RESET = 16'h0000;
	localparam logic [31:0] DUMMY_RESET = 32'h0000_0000;

	// ==========================================================
	// FIFO geometry and timing counts
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
	localparam logic [3:0] FIFO_HALF_CNT = 4'h4;
	localparam logic [5:0] RX_TIMEOUT_SCK = 6'h20;

	// ==========================================================
	// Types
	typedef enum logic [0:0] {
		AP_IDLE = 1'b0,
		AP_DONE = 1'b1
	} apb_state_t;

	typedef enum logic [0:0] {
		RCV_IDLE = 1'b0,
		RCV_ACTIVE = 1'b1
	} rcv_state_t;

	typedef struct packed {
		logic empty;
		logic full;
		logic [3:0] count;
	} fifo_stat_t;

endpackage

// ---- rtl/spi_bit_sync.sv ----
// Two-stage synchroniser with rising edge detect.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module spi_bit_sync (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic din, // Asynchronous level
	output logic level, // Synchronised level
	output logic rise // One-cycle pulse on rising edge
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} sync_t;

	sync_t s;
	sync_t next_s;

	// ==========================================================
	// Next state: first stage feeds only the second
	always_comb begin
		next_s = s;
		next_s.meta = din;
		next_s.sync = s.meta;
		next_s.prev = s.sync;
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.sync;
	assign rise = s.sync & ~s.prev;
endmodule

// ---- rtl/spi_fifo.sv ----
// Flip-flop FIFO of 32-bit words, fixed depth.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
module spi_fifo (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic push, // Write one word
	input wire logic [31:0] push_data, // Word to write
	input wire logic pop, // Remove head word
	output logic [31:0] head, // Head word
	output spi_ctrl_pkg::fifo_stat_t stat // Empty, full, count
);
	typedef struct packed {
		logic [spi_ctrl_pkg::FIFO_DEPTH-1:0][31:0] mem;
		logic [spi_ctrl_pkg::FIFO_AW-1:0] wr;
		logic [spi_ctrl_pkg::FIFO_AW-1:0] rd;
		logic [3:0] cnt;
	} fifo_t;

	fifo_t s;
	fifo_t next_s;
	logic do_push;
	logic do_pop;

	// Push is dropped when full, pop ignored when empty
	assign do_push = push & (s.cnt != spi_ctrl_pkg::FIFO_FULL_CNT);
	assign do_pop = pop & (s.cnt != 4'h0);

	// ==========================================================
	// Pointer and count update
	always_comb begin
		next_s = s;
		if (do_push) begin
			next_s.mem[s.wr] = push_data;
			next_s.wr = s.wr + 3'h1;
		end
		if (do_pop) begin
			next_s.rd = s.rd + 3'h1;
		end
		case ({do_push, do_pop})
			2'b10: next_s.cnt = s.cnt + 4'h1;
			2'b01: next_s.cnt = s.cnt - 4'h1;
			default: next_s.cnt = s.cnt;
		endcase
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign head = s.mem[s.rd];
	assign stat.empty = (s.cnt == 4'h0);
	assign stat.full = (s.cnt == spi_ctrl_pkg::FIFO_FULL_CNT);
	assign stat.count = s.cnt;
endmodule

// ---- rtl/spi_irq_dma_fifo_ctrl.sv ----
// SPI controller slice: interrupt status and clear, DMA request enables,
// frame counts, dummy character and FIFO swap test port behind APB.
// Assumes the shift engine runs on CLK_SYS and asks for one transmit word
// per frame; the link clock pin is asynchronous and is synchronised here.
//
// Function
// R01: Masked status bit n equals raw status bit n ANDed with mask bit n, bits 0 to 5.
// R02: Masked status bits 31 to 6 read zero and all masked bits are zero after reset.
// R03: Writing one to clear bit 0 clears the latched receive overrun condition.
// R04: Writing one to clear bit 1 clears the latched receive timeout condition.
// R05: Writing one to clear bit 2 clears the latched transmit underrun condition.
// R06: DMA control bit 0 enables single receive DMA requests, reset value zero.
// R07: DMA control bit 2 enables single transmit DMA requests, bit 1 is reserved.
// R08: A 16-bit receive frame count resets to zero and sets how many frames to receive.
// R09: A 16-bit count resets to zero and sets how many frames come from the transmit FIFO.
// R10: With swap clear, test port writes push the transmit FIFO and reads pop the receive FIFO.
// R11: With swap set, test port writes push the receive FIFO and reads pop the transmit FIFO; a write in the same cycle as ENG_RX_VALID is dropped.
// R12: Each test port read in swap mode removes that entry from the transmit FIFO.
// R13: Software writes reserved fields only with their reset values.
// R14: Mask bits 0 to 5 reset to zero and enable their interrupt, overrun is a full receive FIFO write.
// R15: Raw status is overrun, timeout, receive, transmit, underrun, empty at bits 0 to 5.
// R16: An empty transmit FIFO during a counted receive sends the dummy character.
// R17: Writing zero to a clear bit does nothing and the clear register reads zero.
`timescale 1ns/1ns
module spi_irq_dma_fifo_ctrl (
	input wire logic CLK_SYS, // System clock, 250 MHz
	input wire logic RST, // Async reset, high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB write
	input wire logic [11:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error on unmapped address
	output logic IRQ, // Level interrupt
	output logic RX_DMA_SREQ, // Single receive DMA request
	output logic TX_DMA_SREQ, // Single transmit DMA request
	input wire logic LINK_SCK, // Serial link clock pin
	input wire logic ENG_TX_REQ, // Engine wants next transmit word
	output logic [31:0] ENG_TX_DATA, // Word for the engine
	output logic ENG_TX_VALID, // Pulse, ENG_TX_DATA is new
	input wire logic ENG_RX_VALID, // Engine delivers a received word
	input wire logic [31:0] ENG_RX_DATA, // Received word
	output logic RX_BUSY // Counted receive in progress
);
	// ==========================================================
	// State
	typedef struct packed {
		spi_ctrl_pkg::apb_state_t apb;
		logic [31:0] prdata;
		logic pslverr;
		logic [5:0] imsc;
		logic ror;
		logic rt;
		logic tur;
		logic dma_rx;
		logic dma_tx;
		logic [15:0] rx_frames;
		logic [31:0] dummy;
		logic [15:0] tx_frames;
		logic swap;
		spi_ctrl_pkg::rcv_state_t rcv;
		logic [15:0] frames_left;
		logic [15:0] tx_left;
		logic [5:0] tout_cnt;
		logic [31:0] eng_data;
		logic eng_valid;
	} ctl_t;

	ctl_t s;
	ctl_t next_s;

	logic [31:0] tx_head;
	logic [31:0] rx_head;
	spi_ctrl_pkg::fifo_stat_t tx_stat;
	spi_ctrl_pkg::fifo_stat_t rx_stat;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic [31:0] tx_push_data;
	logic [31:0] rx_push_data;
	logic sck_rise;
	logic [5:0] raw;
	logic [5:0] masked;
	logic access;
	logic wr_go;
	logic rd_go;
	logic port_wr;
	logic port_rd;
	logic eng_take;
	logic [31:0] rd_word;
	logic mapped;

	// Address match on a word-aligned register
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
		hit = (addr[11:2] == ofs[11:2]);
	endfunction

	// ==========================================================
	// Submodules
	spi_fifo u_tx_fifo (
		.clk(CLK_SYS),
		.rst(RST),
		.push(tx_push),
		.push_data(tx_push_data),
		.pop(tx_pop),
		.head(tx_head),
		.stat(tx_stat)
	);

	spi_fifo u_rx_fifo (
		.clk(CLK_SYS),
		.rst(RST),
		.push(rx_push),
		.push_data(rx_push_data),
		.pop(rx_pop),
		.head(rx_head),
		.stat(rx_stat)
	);

	spi_bit_sync u_sck_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.din(LINK_SCK),
		.level(),
		.rise(sck_rise)
	);

	// ==========================================================
	// APB strobes: request acted on once, in the first access cycle
	assign access = PSEL & PENABLE & (s.apb == spi_ctrl_pkg::AP_IDLE);
	assign wr_go = access & PWRITE;
	assign rd_go = access & ~PWRITE;
	assign port_wr = wr_go & hit(PADDR, spi_ctrl_pkg::OFS_TEST_PORT);
	assign port_rd = rd_go & hit(PADDR, spi_ctrl_pkg::OFS_TEST_PORT);

	// Address map check
	assign mapped = hit(PADDR, spi_ctrl_pkg::OFS_IMSC) | hit(PADDR, spi_ctrl_pkg::OFS_RIS)
		| hit(PADDR, spi_ctrl_pkg::OFS_MASKED_STATUS) | hit(PADDR, spi_ctrl_pkg::OFS_IRQ_CLEAR)
		| hit(PADDR, spi_ctrl_pkg::OFS_DMA_CTRL) | hit(PADDR, spi_ctrl_pkg::OFS_RX_FRAMES)
		| hit(PADDR, spi_ctrl_pkg::OFS_DUMMY) | hit(PADDR, spi_ctrl_pkg::OFS_TX_FRAMES)
		| hit(PADDR, spi_ctrl_pkg::OFS_TEST_CTRL) | hit(PADDR, spi_ctrl_pkg::OFS_TEST_PORT);

	// ==========================================================
	// Raw and masked interrupt status
	always_comb begin
		// R15: raw status order
		raw = 6'h00;
		raw[spi_ctrl_pkg::IRQ_ROR] = s.ror;
		raw[spi_ctrl_pkg::IRQ_RT] = s.rt;
		raw[spi_ctrl_pkg::IRQ_RX] = (rx_stat.count >= spi_ctrl_pkg::FIFO_HALF_CNT);
		raw[spi_ctrl_pkg::IRQ_TX] = (tx_stat.count <= spi_ctrl_pkg::FIFO_HALF_CNT);
		raw[spi_ctrl_pkg::IRQ_TUR] = s.tur;
		raw[spi_ctrl_pkg::IRQ_TE] = tx_stat.empty;
	end

	// R01: mask gating per source
	assign masked = raw & s.imsc;
	// R14: any enabled source drives the line
	assign IRQ = |masked;

	// ==========================================================
	// Transmit word selection for the engine
	// R09: take from FIFO only while the count allows, zero means no limit
	assign eng_take = ENG_TX_REQ & ~tx_stat.empty & ((s.tx_frames == 16'h0000) | (s.tx_left != 16'h0000));

	// FIFO port steering
	always_comb begin
		// R10: normal mode test port targets
		tx_push = port_wr & ~s.swap;
		tx_push_data = PWDATA;
		rx_pop = port_rd & ~s.swap;
		// R11: swapped mode test port targets
		rx_push = ENG_RX_VALID | (port_wr & s.swap);
		rx_push_data = ENG_RX_VALID ? ENG_RX_DATA : PWDATA;
		// R12: swap read drains the transmit FIFO
		tx_pop = eng_take | (port_rd & s.swap);
	end

	// ==========================================================
	// Read data multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit(PADDR, spi_ctrl_pkg::OFS_IMSC)) begin
			rd_word[5:0] = s.imsc;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_RIS)) begin
			rd_word[5:0] = raw;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_MASKED_STATUS)) begin
			// R02: upper bits stay zero
			rd_word[5:0] = masked;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_DMA_CTRL)) begin
			rd_word[spi_ctrl_pkg::DMA_RX_BIT] = s.dma_rx;
			rd_word[spi_ctrl_pkg::DMA_TX_BIT] = s.dma_tx;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_RX_FRAMES)) begin
			rd_word[15:0] = s.rx_frames;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_DUMMY)) begin
			rd_word = s.dummy;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_TX_FRAMES)) begin
			rd_word[15:0] = s.tx_frames;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_TEST_CTRL)) begin
			rd_word[spi_ctrl_pkg::SWAP_BIT] = s.swap;
		end else if (hit(PADDR, spi_ctrl_pkg::OFS_TEST_PORT)) begin
			rd_word = s.swap ? tx_head : rx_head;
		end
		// R17: the clear register falls through and reads zero
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.eng_valid = 1'b0;

		// APB phase tracking, answer one cycle after the first access cycle
		case (s.apb)
			spi_ctrl_pkg::AP_IDLE: begin
				if (access) begin
					next_s.apb = spi_ctrl_pkg::AP_DONE;
					next_s.prdata = PWRITE ? 32'h0000_0000 : rd_word;
					next_s.pslverr = ~mapped;
				end
			end
			spi_ctrl_pkg::AP_DONE: begin
				next_s.apb = spi_ctrl_pkg::AP_IDLE;
				next_s.pslverr = 1'b0;
			end
			default: next_s.apb = spi_ctrl_pkg::AP_IDLE;
		endcase

		// Register writes; R13: reserved bits are not stored
		if (wr_go) begin
			if (hit(PADDR, spi_ctrl_pkg::OFS_IMSC)) begin
				next_s.imsc = PWDATA[5:0];
			end
			if (hit(PADDR, spi_ctrl_pkg::OFS_DMA_CTRL)) begin
				// R06: receive DMA enable
				next_s.dma_rx = PWDATA[spi_ctrl_pkg::DMA_RX_BIT];
				// R07: transmit DMA enable
				next_s.dma_tx = PWDATA[spi_ctrl_pkg::DMA_TX_BIT];
			end
			if (hit(PADDR, spi_ctrl_pkg::OFS_RX_FRAMES)) begin
				// R08: load receive frame count and start counting when it is not zero
				next_s.rx_frames = PWDATA[15:0];
				next_s.frames_left = PWDATA[15:0];
				next_s.rcv = (PWDATA[15:0] != 16'h0000) ? spi_ctrl_pkg::RCV_ACTIVE : spi_ctrl_pkg::RCV_IDLE;
			end
			if (hit(PADDR, spi_ctrl_pkg::OFS_DUMMY)) begin
				next_s.dummy = PWDATA;
			end
			if (hit(PADDR, spi_ctrl_pkg::OFS_TX_FRAMES)) begin
				next_s.tx_frames = PWDATA[15:0];
				next_s.tx_left = PWDATA[15:0];
			end
			if (hit(PADDR, spi_ctrl_pkg::OFS_TEST_CTRL)) begin
				next_s.swap = PWDATA[spi_ctrl_pkg::SWAP_BIT];
			end
			if (hit(PADDR, spi_ctrl_pkg::OFS_IRQ_CLEAR)) begin
				// R17: only ones clear
				// R03: clear overrun
				if (PWDATA[spi_ctrl_pkg::CLR_ROR]) begin
					next_s.ror = 1'b0;
				end
				// R04: clear timeout
				if (PWDATA[spi_ctrl_pkg::CLR_RT]) begin
					next_s.rt = 1'b0;
					next_s.tout_cnt = 6'h00;
				end
				// R05: clear underrun
				if (PWDATA[spi_ctrl_pkg::CLR_TUR]) begin
					next_s.tur = 1'b0;
				end
			end
		end

		// Counted receive sequencing
		case (s.rcv)
			spi_ctrl_pkg::RCV_IDLE: begin
				next_s.frames_left = next_s.frames_left;
			end
			spi_ctrl_pkg::RCV_ACTIVE: begin
				if (ENG_RX_VALID) begin
					next_s.frames_left = s.frames_left - 16'h0001;
					if (s.frames_left == 16'h0001) begin
						next_s.rcv = spi_ctrl_pkg::RCV_IDLE;
					end
				end
			end
			default: next_s.rcv = spi_ctrl_pkg::RCV_IDLE;
		endcase

		// Transmit word for the engine
		if (ENG_TX_REQ) begin
			next_s.eng_valid = 1'b1;
			if (eng_take) begin
				next_s.eng_data = tx_head;
				if (s.tx_left != 16'h0000) begin
					next_s.tx_left = s.tx_left - 16'h0001;
				end
			end else begin
				// R16: dummy character keeps the clock going
				next_s.eng_data = s.dummy;
				if (s.rcv != spi_ctrl_pkg::RCV_ACTIVE) begin
					// Underrun: no FIFO word taken outside a counted receive, set wins
					next_s.tur = 1'b1;
				end
			end
		end

		// R14: overrun when the engine writes a full receive FIFO, set wins
		if (ENG_RX_VALID & rx_stat.full) begin
			next_s.ror = 1'b1;
		end

		// Receive timeout counted in link clock edges while data waits unread
		if (rx_stat.empty | rx_pop) begin
			next_s.tout_cnt = 6'h00;
		end else if (sck_rise & (s.tout_cnt != spi_ctrl_pkg::RX_TIMEOUT_SCK)) begin
			next_s.tout_cnt = s.tout_cnt + 6'h01;
			if (s.tout_cnt == spi_ctrl_pkg::RX_TIMEOUT_SCK - 6'h01) begin
				next_s.rt = 1'b1;
			end
		end
	end

	// ==========================================================
	// Register stage
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			// R02: latched status and all controls start at zero
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign PRDATA = s.prdata;
	assign PREADY = PSEL & PENABLE & (s.apb == spi_ctrl_pkg::AP_DONE);
	assign PSLVERR = PREADY & s.pslverr;
	// R06: receive request while words wait
	assign RX_DMA_SREQ = s.dma_rx & ~rx_stat.empty;
	// R07: transmit request while room remains
	assign TX_DMA_SREQ = s.dma_tx & ~tx_stat.full;
	assign ENG_TX_DATA = s.eng_data;
	assign ENG_TX_VALID = s.eng_valid;
	assign RX_BUSY = (s.rcv == spi_ctrl_pkg::RCV_ACTIVE);
endmodule

// ---- testbench/spi_ctrl_properties.sv ----
// Checker for the SPI control slice: masked status, clear, DMA gates, widths.
// Assumes it is bound to spi_irq_dma_fifo_ctrl and sees only its ports.
`timescale 1ns/1ns
module spi_ctrl_props (
	input wire logic CLK_SYS, // System clock
	input wire logic RST, // Async reset, high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB write
	input wire logic [11:0] PADDR, // APB address
	input wire logic [31:0] PWDATA, // APB write data
	input wire logic [31:0] PRDATA, // APB read data
	input wire logic PREADY, // APB ready
	input wire logic IRQ, // Level interrupt
	input wire logic RX_DMA_SREQ, // Receive DMA request
	input wire logic TX_DMA_SREQ, // Transmit DMA request
	input wire logic ENG_TX_REQ, // Engine asks for a word
	input wire logic ENG_TX_VALID // Word answer pulse
);
	typedef struct packed {
		logic [2:0] dma;
		logic [5:0] mask;
	} shadow_t;
	shadow_t shadow;
	shadow_t next_shadow;
	logic take;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// ==========================================================
	// Shadow of mask and DMA enables, updated at the take edge
	assign take = PSEL && PENABLE && !PREADY && PWRITE;
	always_comb begin
		next_shadow = shadow;
		if (take && PADDR == spi_ctrl_pkg::OFS_DMA_CTRL) begin
			next_shadow.dma = PWDATA[2:0];
		end
		if (take && PADDR == spi_ctrl_pkg::OFS_IMSC) begin
			next_shadow.mask = PWDATA[5:0];
		end
	end
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			shadow <= '0;
		end else begin
			shadow <= next_shadow;
		end
	end

	// ==========================================================
	// Completed read of one address
	sequence s_read(a);
		PSEL && PENABLE && PREADY && !PWRITE && PADDR == a;
	endsequence

	AST_MASKED_STATUS: assert property (s_read(spi_ctrl_pkg::OFS_MASKED_STATUS) |->
		((PRDATA[5:0] & ~$past(shadow.mask)) == 6'h00) && ((PRDATA[5:0] != 6'h00) == $past(IRQ)))
		else $error("masked status disagrees with mask or interrupt");
	AST_MASKED_UPPER: assert property (s_read(spi_ctrl_pkg::OFS_MASKED_STATUS) |->
		PRDATA[31:6] == 26'h000_0000)
		else $error("masked status upper bits not zero");
	AST_IRQ_MASKED: assert property (IRQ |-> shadow.mask != 6'h00)
		else $error("interrupt with all masks clear");
	AST_CLR_READS_ZERO: assert property (s_read(spi_ctrl_pkg::OFS_IRQ_CLEAR) |->
		PRDATA == 32'h0000_0000)
		else $error("clear register read not zero");
	AST_RX_DMA_GATE: assert property (RX_DMA_SREQ |-> shadow.dma[0])
		else $error("receive DMA request while disabled");
	AST_TX_DMA_GATE: assert property (TX_DMA_SREQ |-> shadow.dma[2])
		else $error("transmit DMA request while disabled");
	AST_RX_FRAMES_WIDTH: assert property (s_read(spi_ctrl_pkg::OFS_RX_FRAMES) |->
		PRDATA[31:16] == 16'h0000)
		else $error("receive frame count wider than 16 bits");
	AST_TX_FRAMES_WIDTH: assert property (s_read(spi_ctrl_pkg::OFS_TX_FRAMES) |->
		PRDATA[31:16] == 16'h0000)
		else $error("transmit frame count wider than 16 bits");
	AST_TX_ANSWER: assert property (ENG_TX_REQ |=> ENG_TX_VALID)
		else $error("no transmit word one cycle after request");
	AST_TX_NO_SPURIOUS: assert property (!ENG_TX_REQ |=> !ENG_TX_VALID)
		else $error("transmit word without request");
endmodule

// ---- testbench/spi_far_end.sv ----
// Far-side model: shift engine and slave link, driven by bench task calls.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/1ns
module spi_far_end (
	input wire logic clk, // System clock
	output logic link_sck, // Link clock, low outside frames
	output logic tx_req, // Asks for next word
	input wire logic [31:0] tx_data, // Word from block
	input wire logic tx_valid, // Word is new
	output logic rx_valid, // Pushes a word
	output logic [31:0] rx_data // Received word
);
	// ==========================================================
	// Idle levels at time zero
	initial begin
		link_sck = 1'b0;
		tx_req = 1'b0;
		rx_valid = 1'b0;
		rx_data = 32'h0000_0000;
	end
	// Deliver one received word, then scramble the released data
	task automatic send(input logic [31:0] d);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= d;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~d;
	endtask
	// Ask for one transmit word, take the answer at the next rising edge
	task automatic take(output logic [31:0] d, output logic v);
		@(posedge clk);
		tx_req <= 1'b1;
		@(posedge clk);
		tx_req <= 1'b0;
		@(posedge clk);
		d = tx_data;
		v = tx_valid;
	endtask
	// One frame of n link clock periods of 80 ns, 20 system clocks each
	task automatic frame(input int n);
		repeat (n) begin
			repeat (10) @(posedge clk);
			link_sck <= 1'b1;
			repeat (10) @(posedge clk);
			link_sck <= 1'b0;
		end
	endtask
endmodule

// ---- testbench/tb.sv ----
// Bench for the SPI control slice: register table, interrupts, DMA, swap port.
// Assumes the checker and far-side model are compiled before it.
`timescale 1ns/1ns
module tb;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] w;
		logic [31:0] e;
	} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pready, pslverr, irq, rx_sreq, tx_sreq, link_sck, tx_req, tx_valid, rx_valid, rx_busy, err, v;
	logic [31:0] prdata, tx_data, rx_data, rd;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [11:0] rst_addr [8] = '{12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h080, 12'h014};
	row_t rows [11] = '{'{12'h024, 32'h0000_0005, 32'h0000_0005}, '{12'h024, 32'h0000_0000, 32'h0000_0000},
		'{12'h028, 32'h0000_FFFF, 32'h0000_FFFF}, '{12'h028, 32'h0000_0000, 32'h0000_0000},
		'{12'h02C, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{12'h030, 32'h0000_8001, 32'h0000_8001},
		'{12'h030, 32'h0000_0000, 32'h0000_0000}, '{12'h080, 32'h0000_0002, 32'h0000_0002},
		'{12'h080, 32'h0000_0000, 32'h0000_0000}, '{12'h014, 32'h0000_003F, 32'h0000_003F},
		'{12'h014, 32'h0000_0000, 32'h0000_0000}};

	// ==========================================================
	// Clock, design, far side
	always #2 clk = ~clk;
	spi_irq_dma_fifo_ctrl dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
		.RX_DMA_SREQ(rx_sreq), .TX_DMA_SREQ(tx_sreq), .LINK_SCK(link_sck), .ENG_TX_REQ(tx_req),
		.ENG_TX_DATA(tx_data), .ENG_TX_VALID(tx_valid), .ENG_RX_VALID(rx_valid), .ENG_RX_DATA(rx_data),
		.RX_BUSY(rx_busy));
	spi_far_end far (.clk(clk), .link_sck(link_sck), .tx_req(tx_req), .tx_data(tx_data), .tx_valid(tx_valid),
		.rx_valid(rx_valid), .rx_data(rx_data));

	// ==========================================================
	// Checking, bus tasks, verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Ready is read as it stood just before each rising edge
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n < 20), 32'h0000_0001, "ready wait");
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rdchk(rst_addr[i], 32'h0000_0000, "reset value");
		end
		for (int i = 0; i < 11; i++) begin
			wr(rows[i].a, rows[i].w);
			rdchk(rows[i].a, rows[i].e, "readback");
		end
		chk(32'(rx_busy), 32'h0000_0000, "counted receive ended");
		apb(1'b0, 12'h040, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001, "unmapped error");
		$display("test registers done");
		wr(12'h014, 32'h0000_0010);
		far.take(rd, v);
		chk(rd, 32'hA5A5_5A5A, "dummy word");
		chk(32'(v), 32'h0000_0001, "word valid");
		rdchk(12'h01C, 32'h0000_0010, "underrun masked");
		chk(32'(irq), 32'h0000_0001, "irq raised");
		wr(12'h020, 32'h0000_0000);
		rdchk(12'h01C, 32'h0000_0010, "zero clear kept");
		wr(12'h020, 32'h0000_0004);
		rdchk(12'h01C, 32'h0000_0000, "underrun cleared");
		chk(32'(irq), 32'h0000_0000, "irq dropped");
		$display("test underrun done");
		wr(12'h014, 32'h0000_0003);
		wr(12'h024, 32'h0000_0001);
		for (int i = 0; i < 9; i++) begin
			far.send(32'h0000_1000 + i);
		end
		rdchk(12'h01C, 32'h0000_0001, "overrun");
		chk(32'(rx_sreq), 32'h0000_0001, "rx dma");
		wr(12'h020, 32'h0000_0001);
		rdchk(12'h01C, 32'h0000_0000, "overrun cleared");
		far.frame(36);
		rdchk(12'h01C, 32'h0000_0002, "timeout");
		wr(12'h020, 32'h0000_0002);
		rdchk(12'h01C, 32'h0000_0000, "timeout cleared");
		for (int i = 0; i < 8; i++) begin
			rdchk(12'h08C, 32'h0000_1000 + i, "rx pop");
		end
		chk(32'(rx_sreq), 32'h0000_0000, "rx dma idle");
		$display("test receive done");
		wr(12'h014, 32'h0000_0020);
		wr(12'h024, 32'h0000_0004);
		chk(32'(tx_sreq), 32'h0000_0001, "tx dma");
		rdchk(12'h01C, 32'h0000_0020, "tx empty");
		wr(12'h08C, 32'h1111_0001);
		wr(12'h08C, 32'h1111_0002);
		rdchk(12'h01C, 32'h0000_0000, "tx filled");
		far.take(rd, v);
		chk(rd, 32'h1111_0001, "fifo word");
		wr(12'h080, 32'h0000_0002);
		rdchk(12'h08C, 32'h1111_0002, "purge");
		rdchk(12'h01C, 32'h0000_0020, "purged");
		wr(12'h08C, 32'h2222_0003);
		wr(12'h080, 32'h0000_0000);
		rdchk(12'h01C, 32'h0000_0020, "tx untouched");
		rdchk(12'h08C, 32'h2222_0003, "swap push");
		wr(12'h024, 32'h0000_0000);
		chk(32'(tx_sreq), 32'h0000_0000, "tx dma off");
		$display("test transmit done");
		wr(12'h028, 32'h0000_0003);
		chk(32'(rx_busy), 32'h0000_0001, "counted receive on");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({irq, rx_sreq, tx_sreq, rx_busy, tx_valid}), 32'h0000_0000, "outputs in reset");
		rst <= 1'b0;
		rdchk(12'h028, 32'h0000_0000, "frames after reset");
		rdchk(12'h014, 32'h0000_0000, "mask after reset");
		rdchk(12'h01C, 32'h0000_0000, "status after reset");
		$display("test reset done");
		finish_test();
	end
endmodule

bind spi_irq_dma_fifo_ctrl spi_ctrl_props u_props (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
	.PRDATA, .PREADY, .IRQ, .RX_DMA_SREQ, .TX_DMA_SREQ, .ENG_TX_REQ, .ENG_TX_VALID);
